/* design/seea_pkg.sv */
// constants and register layout of the serial eeprom software access block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package seea_pkg;

  // ----------------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------------
  localparam int unsigned REG_AW = 12;
  localparam logic [REG_AW-1:0] OFS_ACCESS_CTRL = 12'h0B4;
  localparam logic [REG_AW-1:0] OFS_IRQ_STATUS = 12'h0C0;
  localparam logic [REG_AW-1:0] OFS_IRQ_ENABLE = 12'h0C4;
  localparam logic [REG_AW-1:0] OFS_IRQ_CLEAR = 12'h0C8;

  // access control field layout
  localparam int unsigned ADDR_LSB = 0;
  localparam int unsigned ADDR_MSB = 15;
  localparam int unsigned DATA_LSB = 16;
  localparam int unsigned DATA_MSB = 23;
  localparam int unsigned BUSY_BIT = 24;
  localparam int unsigned DONE_BIT = 25;
  localparam int unsigned OPSEL_BIT = 26;
  localparam logic OPSEL_WRITE = 1'h0;
  localparam logic OPSEL_READ = 1'h1;

  // interrupt event layout
  localparam int unsigned EVT_W = 2;
  localparam int unsigned EVT_DONE = 0;
  localparam int unsigned EVT_REFUSED = 1;
  localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;

  // reset values
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // ----------------------------------------------------------------------------
  // serial link timing and framing
  // ----------------------------------------------------------------------------
  localparam int unsigned SYS_CLK_PERIOD_NS = 10;
  localparam int unsigned SCK_HALF_NS = 50;
  // least time: round up to whole cycles
  localparam int unsigned SCK_HALF_CYC = (SCK_HALF_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int unsigned DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCK_HALF_CYC - 1);
  localparam int unsigned FRAME_BITS = 32;
  localparam logic [4:0] BIT_LAST = 5'h1F;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h02;

  typedef enum logic [1:0] {
    SEEA_IDLE = 2'b00,
    SEEA_SHIFT = 2'b01,
    SEEA_FINISH = 2'b10
  } seea_state_t;

endpackage : seea_pkg

/* design/seea_xfer_if.sv */
// request and answer bundle between register front end and serial engine
`timescale 1ns/1ps
interface seea_xfer_if;
  logic start;
  logic is_read;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;

  modport ctl (output start, output is_read, output addr, output wdata, input done, input rdata);
  modport eng (input start, input is_read, input addr, input wdata, output done, output rdata);
endinterface : seea_xfer_if

/* design/seea_serial_engine.sv */
// serial engine: one framed byte transfer to the external eeprom
`timescale 1ns/1ps
module seea_serial_engine (
  input wire logic sys_clk,
  input wire logic srst,
  seea_xfer_if.eng xfer,
  output logic ee_sck,
  output logic ee_cs_n,
  output logic ee_mosi,
  input wire logic ee_miso
);

  seea_pkg::seea_state_t state_ff;
  logic [seea_pkg::DIV_W-1:0] div_ff;
  logic [4:0] bit_ff;
  logic [seea_pkg::FRAME_BITS-1:0] tx_ff;
  logic [7:0] rx_ff;
  logic sck_ff;
  logic cs_n_ff;
  logic done_ff;
  logic [7:0] rdata_ff;
  logic miso_meta_ff;
  logic miso_ff;

  wire div_wrap = (div_ff == seea_pkg::DIV_LAST);
  wire last_bit = (bit_ff == seea_pkg::BIT_LAST);
  // command byte picks the transfer type, address and byte follow msb first
  wire [7:0] cmd = xfer.is_read ? seea_pkg::CMD_READ : seea_pkg::CMD_WRITE;
  // a read sends don't-care zeros in the data slot
  wire [7:0] out_byte = xfer.is_read ? 8'h00 : xfer.wdata;
  wire [seea_pkg::FRAME_BITS-1:0] frame = {cmd, xfer.addr, out_byte};

  // ----------------------------------------------------------------------------
  // pin input synchroniser
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    miso_meta_ff <= ee_miso;
    miso_ff <= miso_meta_ff;
  end

  // ----------------------------------------------------------------------------
  // frame sequencer, mode 0: shift on falling, sample on rising
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_ff <= seea_pkg::SEEA_IDLE;
      div_ff <= '0;
      bit_ff <= '0;
      tx_ff <= '0;
      rx_ff <= 8'h00;
      sck_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      done_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        seea_pkg::SEEA_IDLE: begin
          if (xfer.start) begin
            tx_ff <= frame;
            cs_n_ff <= 1'b0;
            div_ff <= '0;
            bit_ff <= '0;
            state_ff <= seea_pkg::SEEA_SHIFT;
          end
        end
        seea_pkg::SEEA_SHIFT: begin
          div_ff <= div_wrap ? '0 : div_ff + 1'b1;
          if (div_wrap && !sck_ff) begin
            sck_ff <= 1'b1;
            rx_ff <= {rx_ff[6:0], miso_ff};
          end else if (div_wrap) begin
            sck_ff <= 1'b0;
            tx_ff <= {tx_ff[seea_pkg::FRAME_BITS-2:0], 1'b0};
            bit_ff <= bit_ff + 1'b1;
            if (last_bit) begin
              state_ff <= seea_pkg::SEEA_FINISH;
            end
          end
        end
        seea_pkg::SEEA_FINISH: begin
          // chip select released in the same cycle done is reported, so a new frame starts clean
          cs_n_ff <= 1'b1;
          done_ff <= 1'b1;
          rdata_ff <= rx_ff;
          state_ff <= seea_pkg::SEEA_IDLE;
        end
        default: begin
          state_ff <= seea_pkg::SEEA_IDLE;
        end
      endcase
    end
  end

  assign xfer.done = done_ff;
  assign xfer.rdata = rdata_ff;
  assign ee_sck = sck_ff;
  assign ee_cs_n = cs_n_ff;
  assign ee_mosi = tx_ff[seea_pkg::FRAME_BITS-1];

endmodule : seea_serial_engine

/* design/seea_access.sv */
// top: software register access to single bytes of a serial eeprom
`timescale 1ns/1ps
module seea_access (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [seea_pkg::REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic ee_sck,
  output logic ee_cs_n,
  output logic ee_mosi,
  input wire logic ee_miso
);

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  logic [15:0] addr_ff;
  logic [7:0] data_ff;
  logic op_ff;
  logic busy_ff;
  logic done_ff;
  logic [seea_pkg::EVT_W-1:0] sts_ff;
  logic [seea_pkg::EVT_W-1:0] ien_ff;
  logic irq_ff;
  logic [31:0] rdata_ff;
  logic start_ff;
  logic is_read_ff;

  seea_xfer_if xfer ();

  // ----------------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------------
  wire sel_ctrl = (reg_addr == seea_pkg::OFS_ACCESS_CTRL);
  wire sel_sts = (reg_addr == seea_pkg::OFS_IRQ_STATUS);
  wire sel_ien = (reg_addr == seea_pkg::OFS_IRQ_ENABLE);
  wire sel_clr = (reg_addr == seea_pkg::OFS_IRQ_CLEAR);
  wire wr_ctrl = reg_wr && sel_ctrl;

  // a word write always carries the data byte, so each one made while idle is a start request
  wire req_start = wr_ctrl && !busy_ff;
  // writes that land while a transfer runs are dropped and flagged
  wire req_refused = wr_ctrl && busy_ff;
  wire op_new = reg_wdata[seea_pkg::OPSEL_BIT];
  wire done_clr = wr_ctrl && reg_wdata[seea_pkg::DONE_BIT];
  wire eng_done = xfer.done;

  // ----------------------------------------------------------------------------
  // next values of the access control fields
  // ----------------------------------------------------------------------------
  logic [15:0] nxt_addr;
  logic [7:0] nxt_data;
  logic nxt_op;
  logic nxt_busy;
  logic nxt_done;

  always_comb begin
    nxt_addr = addr_ff;
    nxt_data = data_ff;
    nxt_op = op_ff;
    nxt_busy = busy_ff;
    nxt_done = done_ff;
    if (req_start) begin
      nxt_addr = reg_wdata[seea_pkg::ADDR_MSB:seea_pkg::ADDR_LSB];
      nxt_op = op_new;
      // both ops keep the written byte visible; a read replaces it with the eeprom byte at completion
      nxt_data = reg_wdata[seea_pkg::DATA_MSB:seea_pkg::DATA_LSB];
      nxt_busy = 1'b1;
      nxt_done = 1'b0;
    end else if (done_clr) begin
      nxt_done = 1'b0;
    end
    // completion: busy falls in the same cycle done rises, and beats a clear
    if (eng_done) begin
      nxt_busy = 1'b0;
      nxt_done = 1'b1;
      if (op_ff == seea_pkg::OPSEL_READ) begin
        nxt_data = xfer.rdata;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // access control register
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      addr_ff <= seea_pkg::ADDR_RESET;
      data_ff <= seea_pkg::DATA_RESET;
      op_ff <= seea_pkg::OPSEL_WRITE;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
      op_ff <= nxt_op;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  // ----------------------------------------------------------------------------
  // engine request: one-cycle start with the freshly written fields
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      start_ff <= 1'b0;
      is_read_ff <= 1'b0;
    end else begin
      start_ff <= req_start;
      if (req_start) begin
        is_read_ff <= (op_new == seea_pkg::OPSEL_READ);
      end
    end
  end

  // engine takes the held fields, so a later change cannot corrupt a frame
  assign xfer.start = start_ff;
  assign xfer.is_read = is_read_ff;
  assign xfer.addr = addr_ff;
  assign xfer.wdata = data_ff;

  seea_serial_engine u_engine (
    .sys_clk(sys_clk),
    .srst(srst),
    .xfer(xfer),
    .ee_sck(ee_sck),
    .ee_cs_n(ee_cs_n),
    .ee_mosi(ee_mosi),
    .ee_miso(ee_miso)
  );

  // ----------------------------------------------------------------------------
  // interrupt status, enable and clear
  // ----------------------------------------------------------------------------
  wire [seea_pkg::EVT_W-1:0] evt_set = {req_refused, eng_done};
  wire [seea_pkg::EVT_W-1:0] evt_clr = (reg_wr && sel_clr) ? reg_wdata[seea_pkg::EVT_W-1:0] : '0;
  // set wins over clear so an event in the clear cycle survives
  wire [seea_pkg::EVT_W-1:0] nxt_sts = (sts_ff & ~evt_clr) | evt_set;
  wire [seea_pkg::EVT_W-1:0] nxt_ien = (reg_wr && sel_ien) ? reg_wdata[seea_pkg::EVT_W-1:0] : ien_ff;
  wire nxt_irq = |(nxt_sts & nxt_ien);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sts_ff <= seea_pkg::EVT_RESET;
      ien_ff <= seea_pkg::EVT_RESET;
      irq_ff <= 1'b0;
    end else begin
      sts_ff <= nxt_sts;
      ien_ff <= nxt_ien;
      irq_ff <= nxt_irq;
    end
  end

  // ----------------------------------------------------------------------------
  // read path: data in the cycle after the strobe, unmapped reads zero
  // ----------------------------------------------------------------------------
  logic [31:0] ctrl_view;
  logic [31:0] rd_mux;

  always_comb begin
    ctrl_view = 32'h0000_0000;
    ctrl_view[seea_pkg::ADDR_MSB:seea_pkg::ADDR_LSB] = addr_ff;
    ctrl_view[seea_pkg::DATA_MSB:seea_pkg::DATA_LSB] = data_ff;
    ctrl_view[seea_pkg::BUSY_BIT] = busy_ff;
    ctrl_view[seea_pkg::DONE_BIT] = done_ff;
    ctrl_view[seea_pkg::OPSEL_BIT] = op_ff;
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_ctrl) begin
      rd_mux = ctrl_view;
    end else if (sel_sts) begin
      rd_mux[seea_pkg::EVT_W-1:0] = sts_ff;
    end else if (sel_ien) begin
      rd_mux[seea_pkg::EVT_W-1:0] = ien_ff;
    end
  end

  // holds zero outside the answer cycle to keep the bus quiet
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq = irq_ff;

endmodule : seea_access

/* test/seea_eeprom_model.sv */
// behavioural serial eeprom answering single byte frames
`timescale 1ns/1ps
module seea_eeprom_model (
  input wire logic ee_sck,
  input wire logic ee_cs_n,
  input wire logic ee_mosi,
  output logic ee_miso
);
  logic [7:0] mem [logic [15:0]];
  logic [31:0] sh = 32'h0;
  logic [7:0] q = 8'h00;
  logic rdop = 1'b0;
  int n = 0;
  initial ee_miso = 1'b0;
  // frame start: bit count restarts
  always @(negedge ee_cs_n) begin
    n = 0;
    rdop = 1'b0;
  end
  // mode 0: take mosi on the rising serial clock
  always @(posedge ee_sck) if (!ee_cs_n) begin
    sh = {sh[30:0], ee_mosi};
    n = n + 1;
    if (n == 24) begin
      rdop = sh[23:16] == seea_pkg::CMD_READ;
      // unwritten cells give a pattern, not zero, so a stuck bus shows
      q = mem.exists(sh[15:0]) ? mem[sh[15:0]] : sh[7:0] ^ 8'h5A;
    end
  end
  // read byte msb first, launched on the falling clock
  always @(negedge ee_sck) if (!ee_cs_n && rdop && n >= 24 && n < 32) begin
    ee_miso <= q[31-n];
  end
  // frame end: commit a write, and the released line flips
  always @(posedge ee_cs_n) begin
    if (n == 32 && sh[31:24] == seea_pkg::CMD_WRITE) begin
      mem[sh[23:8]] = sh[7:0];
    end
    ee_miso <= ~ee_miso;
  end
endmodule : seea_eeprom_model

/* test/seea_access_props.sv */
// checker of the serial eeprom access block, watching the top ports
`timescale 1ns/1ps
module seea_access_props (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [seea_pkg::REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic irq,
  input wire logic ee_sck,
  input wire logic ee_cs_n,
  input wire logic ee_mosi,
  input wire logic ee_miso
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic act_ff, cs_ff, sck_ff;
  logic [26:0] req_ff;
  logic [31:0] sh_ff;
  logic [5:0] nrise_ff;
  wire logic sel = reg_addr == seea_pkg::OFS_ACCESS_CTRL;
  wire logic go = reg_wr && sel && !act_ff;
  wire logic end_frm = ee_cs_n && !cs_ff;
  // shadow of busy and of the accepted request, and the bits seen on mosi
  always_ff @(posedge sys_clk) begin
    cs_ff <= srst | ee_cs_n;
    sck_ff <= ee_sck;
    if (srst) begin
      act_ff <= 1'b0;
      req_ff <= 27'h0;
      sh_ff <= 32'h0;
      nrise_ff <= 6'h00;
    end else begin
      act_ff <= go | (act_ff & !end_frm);
      if (go) req_ff <= reg_wdata[26:0];
      if (!ee_cs_n && cs_ff) nrise_ff <= 6'h00;
      else if (ee_sck && !sck_ff) nrise_ff <= nrise_ff + 6'h01;
      if (ee_sck && !sck_ff) sh_ff <= {sh_ff[30:0], ee_mosi};
    end
  end
  a_sck_framed: assert property (ee_cs_n |-> !ee_sck) else $error("clock outside frame");
  a_start_frame: assert property (go |-> ##[2:5] $fell(ee_cs_n)) else $error("no frame");
  a_frame_bits: assert property ($rose(ee_cs_n) |-> nrise_ff == 6'h20) else $error("bit count");
  a_frame_addr: assert property ($rose(ee_cs_n) |-> sh_ff[23:8] == req_ff[15:0])
    else $error("address sent");
  a_frame_cmd: assert property ($rose(ee_cs_n) |-> sh_ff[31:24] ==
    (req_ff[26] ? seea_pkg::CMD_READ : seea_pkg::CMD_WRITE)) else $error("command sent");
  a_frame_wdata: assert property ($rose(ee_cs_n) && !req_ff[26] |-> sh_ff[7:0] == req_ff[23:16])
    else $error("byte sent");
  a_read_busy: assert property (reg_rd && sel && act_ff && !ee_cs_n |=>
    reg_rdata[31:24] == {5'h00, req_ff[26], 2'b01}) else $error("busy view");
  a_read_idle: assert property (reg_rd && sel && !act_ff && !$past(act_ff) |=>
    !reg_rdata[24] && reg_rdata[15:0] == req_ff[15:0]) else $error("idle view");
endmodule : seea_access_props

bind seea_access seea_access_props i_props (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
  .ee_sck(ee_sck), .ee_cs_n(ee_cs_n), .ee_mosi(ee_mosi), .ee_miso(ee_miso));

/* test/testbench.sv */
// self-checking bench for the serial eeprom access block
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  localparam logic [11:0] CT = seea_pkg::OFS_ACCESS_CTRL;
  logic sys_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic irq, ee_sck, ee_cs_n, ee_mosi, ee_miso;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic [32:0] r;
  int n_fail = 0, check_count = 0, cyc = 0;
  // rows: op, address, byte written, byte expected in the data field
  logic [32:0] rows [5] = '{{1'b0, 16'h1234, 8'hA5, 8'hA5}, {1'b1, 16'h1234, 8'hFF, 8'hA5},
    {1'b1, 16'hFFFF, 8'h00, 8'hA5}, {1'b0, 16'h0000, 8'h3C, 8'h3C}, {1'b1, 16'h0000, 8'h77, 8'h3C}};
  always #5 sys_clk = ~sys_clk;
  seea_access i_dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .ee_sck(ee_sck),
    .ee_cs_n(ee_cs_n), .ee_mosi(ee_mosi), .ee_miso(ee_miso));
  seea_eeprom_model i_mem (.ee_sck(ee_sck), .ee_cs_n(ee_cs_n), .ee_mosi(ee_mosi), .ee_miso(ee_miso));
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // poll busy; a transfer takes about 324 cycles
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      rd(CT);
      k++;
    end while (d[24] !== 1'b0 && k < 200);
    `CHK(d[24], 1'b0)
  endtask : wait_idle
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // hang guard, well above the few thousand cycles needed
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    rd(CT);
    `CHK(d, 32'h0)
    rd(12'h000);
    `CHK(d, 32'h0)
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      r = rows[i];
      wr(CT, {5'h00, r[32], 2'b00, r[15:8], r[31:16]});
      rd(CT);
      `CHK(d[25:24], 2'b01)
      wait_idle();
      `CHK(d, {5'h00, r[32], 2'b10, r[7:0], r[31:16]})
    end
    $display("test rows done");
    // second request while busy must leave the access control fields untouched
    wr(CT, 32'h0011_0100);
    wr(CT, 32'h0622_0200);
    rd(CT);
    `CHK(d, 32'h0111_0100)
    wait_idle();
    `CHK(d, 32'h0211_0100)
    wr(CT, 32'h0400_0100);
    wait_idle();
    `CHK(d[23:16], 8'h11)
    $display("test refuse done");
    rd(12'h0C0);
    `CHK(d[1:0], 2'b11)
    wr(12'h0C8, 32'h3);
    wr(12'h0C4, 32'h1);
    rd(12'h0C0);
    `CHK(d[1:0], 2'b00)
    `CHK(irq, 1'b0)
    wr(CT, 32'h0000_0005);
    wait_idle();
    repeat (2) @(posedge sys_clk);
    #1 `CHK(irq, 1'b1)
    wr(12'h0C4, 32'h0);
    repeat (2) @(posedge sys_clk);
    #1 `CHK(irq, 1'b0)
    $display("test irq done");
    // reset in mid-frame: the cut frame commits nothing, registers clear
    wr(CT, 32'h0099_0042);
    repeat (40) @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    #1 `CHK({ee_cs_n, ee_sck, irq}, 3'h4)
    rd(CT);
    `CHK(d, 32'h0)
    rd(12'h0C0);
    `CHK(d, 32'h0)
    // unwritten cell answers its pattern, so a committed cut write would show
    wr(CT, 32'h0400_0042);
    wait_idle();
    `CHK(d, 32'h0618_0042)
    $display("test reset mid-run done");
    report_and_stop();
  end
endmodule : testbench
